//--- pkg/sri_pkg.sv
// Constants and types shared by the symbol receive interface
//
// Overview of operation
// - Collision output carries nothing in symbol mode; it is never driven.
// - At 10 Mb/s the symbol receive clock runs at 2.5 MHz.
// - At 100 Mb/s the symbol receive clock runs at 25 MHz.
// - At 10 Mb/s the clock phase is recovered from the incoming media stream.
// - At 10 Mb/s the clock keeps running after the stream ends, on its last phase.
// - At 100 Mb/s the clock follows the stream while a valid link exists.
// - At 100 Mb/s with no link the clock comes from the reference clock.
// - At 10 Mb/s the source changes only after carrier, before the first data.
// - At 10 Mb/s the clock phase is realigned once per packet.
// - At 100 Mb/s the phase is realigned once, at link bring-up only.
// - Symbols leave on a five-bit bus, bit 0 least significant.
// - Every received symbol is passed on continuously, without framing.
// - Receive-data-valid is never asserted and never driven.
// - Symbol outputs change on rising edges of the symbol receive clock.
// - Symbol outputs are gated by the float request input from the MAC.
// - A high float request releases the shared receive bus to another device.
// - A configured device address of zero also floats the receive outputs.
package sri_pkg;

  // ****************************************
  // Clock rates
  // ****************************************
  localparam int SYS_CLK_HZ = 125_000_000;
  localparam int RX_CLK_10_HZ = 2_500_000;
  localparam int RX_CLK_100_HZ = 25_000_000;
  localparam int DIV_W = 8;
  // Divider periods in system clock cycles
  localparam logic [DIV_W-1:0] DIV_10 = DIV_W'(SYS_CLK_HZ / RX_CLK_10_HZ);
  localparam logic [DIV_W-1:0] DIV_100 = DIV_W'(SYS_CLK_HZ / RX_CLK_100_HZ);

  // ****************************************
  // Symbol bus layout and reset values
  // ****************************************
  localparam int SYM_W = 5;
  localparam int SYM_LSB = 0;
  localparam int SYM_MSB = 4;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_FLOAT = 5'h00;
  localparam logic [SYM_W-1:0] SYM_RST = 5'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {ST_REF, ST_LOCK, ST_TRACK, ST_HOLD} sri_state_t;
  typedef enum logic {SRC_REF, SRC_REC} sri_src_t;

  // Media-side word that crosses from the line clock domain
  typedef struct packed {
    logic carrier;
    logic link;
    logic [SYM_MSB:SYM_LSB] sym;
  } sri_line_word_t;

endpackage

//--- hw/sri_sync.sv
// Two-stage synchroniser for levels entering the domain of its clock (system or line)
module sri_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage is read only by the second stage
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end

endmodule

//--- hw/sri_clk_gen.sv
// Symbol clock divider with phase realignment
module sri_clk_gen
  import sri_pkg::*;
#(
  parameter int W = DIV_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic [W-1:0] period,
  input wire logic realign,
  // Generated clock
  output logic level,
  output logic rise
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_level;
  logic next_rise;

  // Realign jumps to the last low count, so a true rise follows next cycle.
  // The phase may jump up to a whole cycle; a rise never comes while high.
  always_comb begin
    next_cnt = W'(cnt + 1'b1);
    if (next_cnt >= period) begin
      next_cnt = '0;
    end
    if (realign) begin
      next_cnt = W'(period - 1'b1);
    end
    next_level = next_cnt < (period >> 1);
    next_rise = (next_cnt == '0) && !level;
  end

  // Divider registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt <= '0;
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      cnt <= next_cnt;
      level <= next_level;
      rise <= next_rise;
    end
  end

endmodule

//--- hw/sri_top.sv
// Receive side of the symbol interface: media capture, clock recovery, pins
module sri_top
  import sri_pkg::*;
(
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Media side, line clock domain
  input wire logic clk_line,
  input wire logic [SYM_MSB:SYM_LSB] line_symbol,
  input wire logic line_symbol_strobe,
  input wire logic line_carrier,
  input wire logic line_link_valid,
  // Straps and MAC control pins, asynchronous
  input wire logic speed_100,
  input wire logic [ADDR_W-1:0] phy_address,
  input wire logic receive_float_request,
  // Symbol receive clock pin
  output logic symbol_receive_clock,
  output logic symbol_receive_clock_oe,
  // Symbol receive data pins
  output logic [SYM_MSB:SYM_LSB] symbol_receive_bits,
  output logic symbol_receive_bits_oe,
  // Symbol carrier sense pin
  output logic symbol_carrier_sense,
  output logic symbol_carrier_sense_oe,
  // Pins that stay unused in symbol mode
  output logic collision_out,
  output logic collision_out_oe,
  output logic receive_data_valid,
  output logic receive_data_valid_oe
);

  // ****************************************
  // Line clock domain
  // ****************************************

  logic line_rst_n;
  sri_line_word_t line_word;
  sri_line_word_t next_line_word;
  logic line_tog;
  logic next_line_tog;

  // Reset reaches the line domain through its own synchroniser.
  // The line clock must run while rst_n is low for this to take.
  sri_sync #(
    .W(1)
  ) u_line_rst (
    .clk(clk_line),
    .d(rst_n),
    .q(line_rst_n)
  );

  // Capture each symbol and toggle to announce it.
  // Levels are sampled every line cycle; the symbol only on its strobe.
  always_comb begin
    next_line_word.carrier = line_carrier;
    next_line_word.link = line_link_valid;
    next_line_word.sym = line_word.sym;
    next_line_tog = line_tog;
    if (line_symbol_strobe) begin
      next_line_word.sym = line_symbol;
      next_line_tog = ~line_tog;
    end
  end

  // Line domain registers
  always_ff @(posedge clk_line) begin
    if (!line_rst_n) begin
      line_word <= '0;
      line_tog <= 1'b0;
    end else begin
      line_word <= next_line_word;
      line_tog <= next_line_tog;
    end
  end

  // ****************************************
  // Crossing into the system domain
  // ****************************************

  logic tog_s;
  logic tog_seen;
  logic next_tog_seen;
  logic carrier_s;
  logic link_s;
  logic speed_s;
  logic float_s;
  logic [ADDR_W-1:0] addr_s;
  logic sym_new;

  // Toggle carries the symbol event; the held word is stable long
  // after the toggle lands, since the line clock is far slower.
  sri_sync #(
    .W(1)
  ) u_tog (
    .clk(clk_sys),
    .d(line_tog),
    .q(tog_s)
  );

  // Carrier and link are plain levels
  sri_sync #(
    .W(2)
  ) u_lvl (
    .clk(clk_sys),
    .d({line_word.carrier, line_word.link}),
    .q({carrier_s, link_s})
  );

  // Straps and the float request come from pins
  sri_sync #(
    .W(ADDR_W + 2)
  ) u_pins (
    .clk(clk_sys),
    .d({speed_100, receive_float_request, phy_address}),
    .q({speed_s, float_s, addr_s})
  );

  // Edge of the synchronised toggle marks a fresh symbol
  always_comb begin
    next_tog_seen = tog_s;
    sym_new = tog_s ^ tog_seen;
  end

  // ****************************************
  // Clock source control
  // ****************************************

  sri_state_t state;
  sri_state_t next_state;
  sri_src_t src;
  sri_src_t next_src;
  logic carrier_d;
  logic link_d;
  logic speed_d;
  logic realign;
  logic carrier_rise;
  logic link_rise;
  logic [DIV_W-1:0] period;

  // Edges of the carrier and link levels
  always_comb begin
    carrier_rise = carrier_s && !carrier_d;
    link_rise = link_s && !link_d;
  end

  // Source state machine.
  // 10 Mb/s: carrier opens a lock window; the first symbol of the
  // packet realigns the phase and the source switches to recovered,
  // all before any data is handed on as valid. When the stream ends
  // the divider keeps its last phase, so the clock never stops.
  // 100 Mb/s: the link level picks the source; the phase is pulled in
  // once when the link comes up and left alone for every packet.
  always_comb begin
    next_state = state;
    next_src = src;
    realign = 1'b0;
    if (speed_s != speed_d) begin
      next_state = ST_REF;
      next_src = SRC_REF;
    end else if (speed_s) begin
      case (state)
        ST_REF: begin
          next_src = SRC_REF;
          if (link_s) begin
            next_state = ST_LOCK;
          end
        end
        ST_LOCK: begin
          if (!link_s) begin
            next_state = ST_REF;
          end else if (sym_new) begin
            realign = 1'b1;
            next_src = SRC_REC;
            next_state = ST_TRACK;
          end
        end
        default: begin
          if (!link_s) begin
            next_state = ST_REF;
            next_src = SRC_REF;
          end
        end
      endcase
    end else begin
      case (state)
        ST_LOCK: begin
          if (!carrier_s) begin
            next_state = ST_HOLD;
          end else if (sym_new) begin
            realign = 1'b1;
            next_src = SRC_REC;
            next_state = ST_TRACK;
          end
        end
        ST_TRACK: begin
          if (!carrier_s) begin
            next_state = ST_HOLD;
          end
        end
        default: begin
          if (carrier_rise) begin
            next_state = ST_LOCK;
          end
        end
      endcase
    end
    // A link that drops and returns in one step still realigns once
    if (speed_s && speed_s == speed_d && link_rise && state == ST_TRACK) begin
      next_state = ST_LOCK;
    end
  end

  // Divider period follows the speed strap
  always_comb begin
    if (speed_s) begin
      period = DIV_100;
    end else begin
      period = DIV_10;
    end
  end

  // Control registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_REF;
      src <= SRC_REF;
      carrier_d <= 1'b0;
      link_d <= 1'b0;
      speed_d <= 1'b0;
      tog_seen <= 1'b0;
    end else begin
      state <= next_state;
      src <= next_src;
      carrier_d <= carrier_s;
      link_d <= link_s;
      speed_d <= speed_s;
      tog_seen <= next_tog_seen;
    end
  end

  // ****************************************
  // Clock generation
  // ****************************************

  logic gen_level;
  logic gen_rise;

  // The divider runs from the system clock, which stands in for the
  // reference; recovery only moves its phase. A realign may shift the
  // phase by up to a full period, which the MAC has to ride out.
  sri_clk_gen #(
    .W(DIV_W)
  ) u_clk_gen (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .period(period),
    .realign(realign),
    .level(gen_level),
    .rise(gen_rise)
  );

  // ****************************************
  // Pin stage
  // ****************************************

  logic drive;
  logic next_clk;
  logic [SYM_MSB:SYM_LSB] next_bits;
  logic next_crs;
  logic [SYM_MSB:SYM_LSB] sym_hold;
  logic [SYM_MSB:SYM_LSB] next_sym_hold;

  // Drive only when the MAC has not asked to float and the address
  // is not the floating one; this keeps a shared bus to one driver.
  always_comb begin
    drive = !float_s && addr_s != ADDR_FLOAT;
  end

  // Latest symbol is held so none is skipped between clock edges.
  // Symbols arriving faster than the output clock overwrite the
  // previous one; the media rate is expected to match the clock.
  always_comb begin
    next_sym_hold = sym_hold;
    if (sym_new) begin
      next_sym_hold = line_word.sym;
    end
  end

  // Data and carrier change together with the clock going high
  always_comb begin
    next_clk = gen_level;
    next_bits = symbol_receive_bits;
    next_crs = symbol_carrier_sense;
    if (gen_rise) begin
      next_bits = next_sym_hold;
      next_crs = carrier_s;
    end
  end

  // Pin registers; unused pins stay released and low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sym_hold <= SYM_RST;
      symbol_receive_clock <= 1'b0;
      symbol_receive_clock_oe <= 1'b0;
      symbol_receive_bits <= SYM_RST;
      symbol_receive_bits_oe <= 1'b0;
      symbol_carrier_sense <= 1'b0;
      symbol_carrier_sense_oe <= 1'b0;
      collision_out <= 1'b0;
      collision_out_oe <= 1'b0;
      receive_data_valid <= 1'b0;
      receive_data_valid_oe <= 1'b0;
    end else begin
      sym_hold <= next_sym_hold;
      symbol_receive_clock <= next_clk;
      symbol_receive_clock_oe <= drive;
      symbol_receive_bits <= next_bits;
      symbol_receive_bits_oe <= drive;
      symbol_carrier_sense <= next_crs;
      symbol_carrier_sense_oe <= drive;
      collision_out <= 1'b0;
      collision_out_oe <= 1'b0;
      receive_data_valid <= 1'b0;
      receive_data_valid_oe <= 1'b0;
    end
  end

endmodule

//--- test/sri_chk.sv
// Pin-level checks for the symbol receive interface
module sri_chk
  import sri_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Straps and float request
  input wire logic speed_100,
  input wire logic [ADDR_W-1:0] phy_address,
  input wire logic receive_float_request,
  // Symbol pins
  input wire logic symbol_receive_clock,
  input wire logic symbol_receive_clock_oe,
  input wire logic [SYM_MSB:SYM_LSB] symbol_receive_bits,
  input wire logic symbol_receive_bits_oe,
  input wire logic symbol_carrier_sense,
  input wire logic symbol_carrier_sense_oe,
  // Unused pins
  input wire logic collision_out,
  input wire logic collision_out_oe,
  input wire logic receive_data_valid,
  input wire logic receive_data_valid_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] oe;
  // *****
  // Assertions
  // *****
  // Enables of the three gated pins side by side
  assign oe = {symbol_receive_clock_oe, symbol_receive_bits_oe, symbol_carrier_sense_oe};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_COL: assert property (!collision_out && !collision_out_oe)
    else $error("collision pin active");
  AST_RXDV: assert property (!receive_data_valid && !receive_data_valid_oe)
    else $error("data valid pin active");
  AST_BITS: assert property ($changed(symbol_receive_bits) |-> $rose(symbol_receive_clock))
    else $error("symbol bits moved off a clock rise");
  AST_CS: assert property ($changed(symbol_carrier_sense) |-> $rose(symbol_receive_clock))
    else $error("carrier sense moved off a clock rise");
  // A floated clock may park, so the period checks pause while released
  AST_P100: assert property (disable iff (!rst_n || !symbol_receive_clock_oe)
    speed_100 && $past(speed_100, 6) && $rose(symbol_receive_clock)
    |-> ##[1:5] $rose(symbol_receive_clock)) else $error("fast clock period too long");
  AST_P10: assert property (disable iff (!rst_n || !symbol_receive_clock_oe)
    !speed_100 && !$past(speed_100, 6) && $rose(symbol_receive_clock)
    |-> ##[1:50] $rose(symbol_receive_clock)) else $error("slow clock period too long");
  AST_FLOAT: assert property (receive_float_request && $past(receive_float_request, 3)
    |-> oe == 3'h0) else $error("pins driven while float requested");
  AST_ADDR0: assert property (phy_address == ADDR_FLOAT
    && $past(phy_address, 3) == ADDR_FLOAT |-> oe == 3'h0) else $error("pins driven at address zero");
  AST_OE_ON: assert property ($past(rst_n, 4) && phy_address != ADDR_FLOAT
    && $past(phy_address, 3) != ADDR_FLOAT && !receive_float_request
    && !$past(receive_float_request, 3) |-> oe == 3'h7) else $error("pins not driven");
endmodule

bind sri_top sri_chk sri_chk_i (.*);

//--- test/sri_mac_model.sv
// Behavioural MAC that takes symbols on rises of the receive clock
module sri_mac_model
  import sri_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Symbol pins from the device
  input wire logic symbol_receive_clock,
  input wire logic [SYM_MSB:SYM_LSB] symbol_receive_bits,
  input wire logic symbol_receive_bits_oe,
  // Captured symbol
  output logic [SYM_MSB:SYM_LSB] last_symbol
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_clock;
  logic [SYM_MSB:SYM_LSB] wire_bits;
  // A released bus shows the inverse, so a floated read never looks right
  assign wire_bits = symbol_receive_bits_oe ? symbol_receive_bits : ~symbol_receive_bits;
  // No period is assumed, so phase jumps are harmless; collision is ignored
  always_ff @(posedge clk_sys) begin
    prev_clock <= symbol_receive_clock;
    if (symbol_receive_clock && !prev_clock) begin
      last_symbol <= wire_bits;
    end
  end
endmodule

//--- test/sri_top_test.sv
// Self-checking bench for the symbol receive interface
module sri_top_test
  import sri_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, clk_line, rst_n, line_symbol_strobe, line_carrier, line_link_valid;
  logic speed_100, receive_float_request, symbol_receive_clock, symbol_receive_clock_oe;
  logic symbol_receive_bits_oe, symbol_carrier_sense, symbol_carrier_sense_oe;
  logic collision_out, collision_out_oe, receive_data_valid, receive_data_valid_oe;
  logic [SYM_MSB:SYM_LSB] line_symbol, symbol_receive_bits, last_symbol;
  logic [ADDR_W-1:0] phy_address;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  sri_top sri_top_i (.*);
  sri_mac_model sri_mac_model_i (.*);
  // Line clock offset so the two domains never share an edge
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    clk_line = 1'b0;
    #37;
    forever #80 clk_line = ~clk_line;
  end
  // *****
  // Helpers
  // *****
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Counts cycles up to the next clock rise, bounded so a stuck clock fails
  task automatic next_rise(output int n);
    logic p;
    n = 0;
    p = 1'b1;
    while (!(symbol_receive_clock === 1'b1 && p === 1'b0) && n < 200) begin
      p = symbol_receive_clock;
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic period(output int n);
    next_rise(n);
    next_rise(n);
  endtask
  // *****
  // Scenarios
  // *****
  task automatic t_float();
    logic [5:0] tbl [5] = '{6'h01, 6'h21, 6'h01, 6'h00, 6'h1f};
    foreach (tbl[i]) begin
      @(posedge clk_sys);
      {receive_float_request, phy_address} <= tbl[i];
      repeat (6) @(negedge clk_sys);
      chk(8'({symbol_receive_clock_oe, symbol_receive_bits_oe, symbol_carrier_sense_oe}),
          (!tbl[i][5] && tbl[i][4:0] != 5'h00) ? 8'h07 : 8'h00);
      chk(8'({collision_out, collision_out_oe, receive_data_valid, receive_data_valid_oe}),
          8'h00);
    end
  endtask
  task automatic t_100();
    logic [4:0] tbl [9] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1f, 5'h00, 5'h15, 5'h0a};
    int n;
    period(n);
    chk(8'(n), 8'(DIV_100));
    @(posedge clk_line);
    line_link_valid <= 1'b1;
    // Back-to-back symbols, each seen two line cycles after it is set
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_line);
      line_symbol <= tbl[i % 9];
      line_symbol_strobe <= (i < 9);
      if (i >= 2) chk(8'(last_symbol), 8'(tbl[i - 2]));
    end
    period(n);
    chk(8'(n), 8'(DIV_100));
  endtask
  task automatic t_10();
    logic [4:0] s;
    int n;
    @(posedge clk_sys);
    speed_100 <= 1'b0;
    repeat (60) @(posedge clk_sys);
    for (int p = 0; p < 2; p++) begin
      period(n);
      chk(8'(n), 8'(DIV_10));
      @(posedge clk_line);
      line_carrier <= 1'b1;
      repeat (2) @(posedge clk_line);
      for (int k = 0; k < 3; k++) begin
        s = 5'(3 + 7 * k + p);
        @(posedge clk_line);
        line_symbol <= s;
        line_symbol_strobe <= 1'b1;
        @(posedge clk_line);
        line_symbol_strobe <= 1'b0;
        n = 0;
        while (symbol_receive_bits !== s && n < 60) begin
          @(negedge clk_sys);
          n++;
        end
        // Only the first symbol of a packet realigns, so only it is prompt
        if (k == 0) chk(8'(n <= 12), 8'h01);
        repeat (4) @(negedge clk_sys);
        chk(8'(last_symbol), 8'(s));
      end
      chk(8'(symbol_carrier_sense), 8'h01);
      @(posedge clk_line);
      line_carrier <= 1'b0;
    end
  endtask
  // Main sequence; line clock keeps running so its reset can pass
  initial begin
    rst_n = 1'b0;
    line_symbol = 5'h00;
    line_symbol_strobe = 1'b0;
    line_carrier = 1'b0;
    line_link_valid = 1'b0;
    speed_100 = 1'b1;
    phy_address = 5'h01;
    receive_float_request = 1'b0;
    repeat (3) @(posedge clk_line);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_line);
    t_float();
    t_100();
    t_10();
    final_report();
  end
  // Cycle ceiling against a hang
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
endmodule
